// file: core/slba_pkg.sv
// constants and types for the segment lookaside bridge access block
// assumes 64-bit general registers numbered with bit 0 as the least significant
package slba_pkg;
    // entry store geometry
    localparam int unsigned NUM_ENTRIES = 16;
    localparam int unsigned IDX_W = 4;
    localparam int unsigned GPR_W = 64;
    localparam int unsigned VIRTUAL_SEGMENT_ID_W = 52;
    // register image positions (little-endian numbering)
    localparam int unsigned GPR_ZERO_HI = 63; // always cleared on reads
    localparam int unsigned GPR_ZERO_LO = 57;
    localparam int unsigned GPR_VHI_HI = 56; // upper virtual segment id part
    localparam int unsigned GPR_VHI_LO = 32;
    localparam int unsigned GPR_TKK_HI = 31; // type, supervisor_key, user_key
    localparam int unsigned GPR_TKK_LO = 29;
    localparam int unsigned GPR_NF_HI = 28; // no-execute / reserved pair
    localparam int unsigned GPR_NF_LO = 27;
    localparam int unsigned GPR_VLO_HI = 26; // lower virtual segment id part
    localparam int unsigned GPR_IDX_HI = 31; // index_gpr select field
    localparam int unsigned GPR_IDX_LO = 28;
    // split of the virtual segment id inside an entry
    localparam int unsigned VIRTUAL_SEGMENT_ID_SPLIT = 27;
    localparam logic [24:0] VHI_ZERO = 25'h0000000; // narrow writes clear the upper part
    localparam logic [6:0] GPR_TOP_ZERO = 7'h00;

    // one lookaside record, written as though from a segment_table_record
    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] effective_segment_id_lo; // effective_segment_id low nibble, upper bits zero
        logic [2:0] tkk;
        logic [1:0] nfield;
        logic [VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id;
    } slba_entry_t;

    localparam slba_entry_t ENTRY_RST = '0;

    // pipeline operations reaching this block
    typedef enum logic [2:0] {
        SLBA_MOVE_TO,
        SLBA_MOVE_TO_IND,
        SLBA_MOVE_FROM,
        SLBA_MOVE_FROM_IND,
        SLBA_MOVE_TO_WIDE,
        SLBA_MOVE_TO_WIDE_IND,
        SLBA_NOP
    } slba_op_t;
endpackage

// file: core/slba_store_if.sv
// port bundle between the access controller and the entry store
// assumes both ends share one clock
interface slba_store_if;
    logic we; // one-cycle write strobe
    logic [slba_pkg::IDX_W-1:0] waddr;
    slba_pkg::slba_entry_t wdata;
    logic [slba_pkg::IDX_W-1:0] raddr;
    slba_pkg::slba_entry_t rdata; // combinational read
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: core/slba_entry_store.sv
// sixteen-record flip-flop store for the segment_lookaside_buffer fixed entries
// assumes writes come from the controller on the same clock
module slba_entry_store #(
    parameter int unsigned DEPTH = slba_pkg::NUM_ENTRIES
) (
    input wire logic clk,
    input wire logic arst_n,
    slba_store_if.store sif
);
    // addresses are four bits wide, so any other depth would leave holes or misses
    if (DEPTH != slba_pkg::NUM_ENTRIES) begin : g_bad_depth
        $error("slba_entry_store: DEPTH must be 16");
    end

    slba_pkg::slba_entry_t mem_q [DEPTH]; // record storage

    // synchronous write port, records cleared at reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= slba_pkg::ENTRY_RST;
            end
        end else if (sif.we) begin
            mem_q[sif.waddr] <= sif.wdata;
        end
    end

    // combinational read port so a move-from answers next edge
    assign sif.rdata = mem_q[sif.raddr];
endmodule

// file: core/slba_bridge.sv
// segment move access control for the fixed lookaside entries
// assumes pipeline inputs are on clk and one operation is offered per cycle at most
// Summary of operation
// - all four narrow moves enabled as one group
// - absent group raises illegal-instruction trap
// - sixteen entries act as segment registers
// - narrow move-to takes low 32 source bits
// - move-from returns full 64-bit image
// - reads after space-valid set flagged undefined
// - fixed sixteen entries, reload uses separate policy
// - every move-to updates replacement history
// - narrow moves illegal without space-valid bit implemented
// - immediate field picks entry; type, keys placed
// - virtual segment id split into two fields
// - top seven result bits forced zero
// - entries not software-written read undefined
// - supervisor only, user gets privileged trap
// - indexed read uses index register bits 28-31
// - narrow write sets valid, zero upper id, copies keys
// - indexed write uses index register bits 28-31
module slba_bridge #(
    parameter bit GROUP_EN = 1'b1, // narrow move group implemented
    parameter bit ASV_IMPL = 1'b1, // addr_space_valid bit implemented
    parameter bit WIDE_EN = 1'b1, // 64-bit move-to pair implemented
    parameter int unsigned NUM_ENTRIES = slba_pkg::NUM_ENTRIES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire slba_pkg::slba_op_t op_code,
    input wire logic [slba_pkg::IDX_W-1:0] segment_index_field,
    input wire logic [slba_pkg::GPR_W-1:0] index_gpr,
    input wire logic [slba_pkg::GPR_W-1:0] source_gpr,
    input wire logic supervisor,
    input wire logic addr_space_valid,
    input wire logic reload_valid,
    input wire logic [slba_pkg::IDX_W-1:0] reload_index,
    output logic result_valid_q,
    output logic [slba_pkg::GPR_W-1:0] result_q,
    output logic result_undef_q,
    output logic illegal_trap_q,
    output logic priv_trap_q,
    output logic hist_update_q,
    output logic [slba_pkg::IDX_W-1:0] hist_index_q
);
    // the index is a four-bit field, so only sixteen records can be served
    if (NUM_ENTRIES != 16) begin : g_bad_depth
        $error("slba_bridge: NUM_ENTRIES must be 16");
    end

    slba_store_if sif (); // bundle to the record store
    logic is_write; // decoded move-to
    logic is_read; // decoded move-from
    logic is_ind; // index comes from index_gpr
    logic is_wide; // 64-bit move-to variant
    logic op_legal; // operation exists on this build
    logic accept; // legal and privileged
    logic [slba_pkg::IDX_W-1:0] sel_idx; // chosen entry
    logic [NUM_ENTRIES-1:0] sw_owned_q; // entry last written by a move-to
    logic [NUM_ENTRIES-1:0] tainted_q; // space-valid seen since that write
    slba_pkg::slba_entry_t new_entry; // record built from source_gpr

    // operation decode; the narrow four share one enable so none exists alone
    always_comb begin
        is_write = 1'b0;
        is_read = 1'b0;
        is_ind = 1'b0;
        is_wide = 1'b0;
        op_legal = 1'b0;
        case (op_code)
            slba_pkg::SLBA_MOVE_TO: begin
                is_write = 1'b1;
                op_legal = GROUP_EN && ASV_IMPL;
            end
            slba_pkg::SLBA_MOVE_TO_IND: begin
                is_write = 1'b1;
                is_ind = 1'b1;
                op_legal = GROUP_EN && ASV_IMPL;
            end
            slba_pkg::SLBA_MOVE_FROM: begin
                is_read = 1'b1;
                op_legal = GROUP_EN && ASV_IMPL;
            end
            slba_pkg::SLBA_MOVE_FROM_IND: begin
                is_read = 1'b1;
                is_ind = 1'b1;
                op_legal = GROUP_EN && ASV_IMPL;
            end
            slba_pkg::SLBA_MOVE_TO_WIDE: begin
                is_write = 1'b1;
                is_wide = 1'b1;
                op_legal = WIDE_EN;
            end
            slba_pkg::SLBA_MOVE_TO_WIDE_IND: begin
                is_write = 1'b1;
                is_wide = 1'b1;
                is_ind = 1'b1;
                op_legal = WIDE_EN;
            end
            default: begin
                // not ours: no trap, no action
            end
        endcase
    end

    // privilege and index selection
    assign accept = op_valid && op_legal && supervisor;
    // indexed forms take index_gpr bits 28-31, the others the immediate field
    assign sel_idx = is_ind ? index_gpr[slba_pkg::GPR_IDX_HI:slba_pkg::GPR_IDX_LO]
                            : segment_index_field;

    // build the record as though loaded from a segment_table_record
    always_comb begin
        new_entry = slba_pkg::ENTRY_RST;
        new_entry.valid = 1'b1;
        new_entry.effective_segment_id_lo = sel_idx;
        new_entry.tkk = source_gpr[slba_pkg::GPR_TKK_HI:slba_pkg::GPR_TKK_LO];
        new_entry.nfield = source_gpr[slba_pkg::GPR_NF_HI:slba_pkg::GPR_NF_LO];
        // narrow writes carry only 32 bits, so the upper id part is zero
        new_entry.virtual_segment_id[slba_pkg::VIRTUAL_SEGMENT_ID_W-1:slba_pkg::VIRTUAL_SEGMENT_ID_SPLIT] = is_wide
            ? source_gpr[slba_pkg::GPR_VHI_HI:slba_pkg::GPR_VHI_LO]
            : slba_pkg::VHI_ZERO;
        new_entry.virtual_segment_id[slba_pkg::VIRTUAL_SEGMENT_ID_SPLIT-1:0] =
            source_gpr[slba_pkg::GPR_VLO_HI:0];
    end

    // store hookup: one write and one read port on the fixed entries
    assign sif.we = accept && is_write;
    assign sif.waddr = sel_idx;
    assign sif.wdata = new_entry;
    assign sif.raddr = sel_idx;

    slba_entry_store #(
        .DEPTH(NUM_ENTRIES)
    ) u_store (
        .clk(clk),
        .arst_n(arst_n),
        .sif(sif)
    );

    // per-entry ownership and staleness; hardware reload takes ownership away
    // and a space-valid cycle wins over a simultaneous write
    for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_flags
        // entry number at index width, so the compares below match bit for bit
        localparam logic [slba_pkg::IDX_W-1:0] ENTRY_IDX = slba_pkg::IDX_W'(e);
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                sw_owned_q[e] <= 1'b0;
            end else if (reload_valid && reload_index == ENTRY_IDX) begin
                sw_owned_q[e] <= 1'b0;
            end else if (sif.we && sif.waddr == ENTRY_IDX) begin
                sw_owned_q[e] <= 1'b1;
            end
        end
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                tainted_q[e] <= 1'b0;
            end else if (addr_space_valid) begin
                tainted_q[e] <= 1'b1;
            end else if (sif.we && sif.waddr == ENTRY_IDX) begin
                tainted_q[e] <= 1'b0;
            end
        end
    end

    // move-from answer, registered one edge after the request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q <= '0;
            result_valid_q <= 1'b0;
            result_undef_q <= 1'b0;
        end else begin
            result_valid_q <= accept && is_read;
            if (accept && is_read) begin
                result_q <= {slba_pkg::GPR_TOP_ZERO,
                             sif.rdata.virtual_segment_id[slba_pkg::VIRTUAL_SEGMENT_ID_W-1:slba_pkg::VIRTUAL_SEGMENT_ID_SPLIT],
                             sif.rdata.tkk, sif.rdata.nfield,
                             sif.rdata.virtual_segment_id[slba_pkg::VIRTUAL_SEGMENT_ID_SPLIT-1:0]};
                result_undef_q <= !sw_owned_q[sel_idx] || tainted_q[sel_idx];
            end
        end
    end

    // traps: a missing group outranks the privilege check
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            illegal_trap_q <= 1'b0;
            priv_trap_q <= 1'b0;
        end else begin
            illegal_trap_q <= op_valid && (is_read || is_write) && !op_legal;
            priv_trap_q <= op_valid && op_legal && !supervisor;
        end
    end

    // replacement history sees each move-to exactly as a reload would
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hist_update_q <= 1'b0;
            hist_index_q <= '0;
        end else begin
            hist_update_q <= sif.we || reload_valid;
            if (sif.we) begin
                hist_index_q <= sif.waddr;
            end else if (reload_valid) begin
                hist_index_q <= reload_index;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    illegal_absent_a: assert property (op_valid && (is_read || is_write) && !op_legal
        && !reload_valid |=> illegal_trap_q && !result_valid_q && !hist_update_q)
        else $error("missing group did not trap");
    user_reject_a: assert property (op_valid && op_legal && !supervisor && !reload_valid
        |=> priv_trap_q && !result_valid_q && !hist_update_q)
        else $error("user-mode move not rejected");
    top_zero_a: assert property (result_valid_q |-> result_q[63:57] == 7'h00)
        else $error("result top bits not zero");
    read_keys_a: assert property (accept && is_read
        |=> result_q[31:27] == {$past(sif.rdata.tkk), $past(sif.rdata.nfield)})
        else $error("key fields misplaced");
    read_virtual_segment_id_a: assert property (accept && is_read
        |=> result_q[56:32] == $past(sif.rdata.virtual_segment_id[51:27])
            && result_q[26:0] == $past(sif.rdata.virtual_segment_id[26:0]))
        else $error("virtual id fields misplaced");
    write_back_a: assert property (accept && is_write && !is_wide ##1
        op_valid && accept && is_read && !is_ind && segment_index_field == $past(sel_idx)
        |=> result_q[31:27] == $past(source_gpr[31:27], 2)
            && result_q[56:32] == 25'h0000000)
        else $error("narrow write not read back");
    index_pick_a: assert property (op_valid && is_ind
        |-> sif.waddr == index_gpr[31:28] && sif.raddr == index_gpr[31:28])
        else $error("indexed form used wrong index");
    hist_touch_a: assert property (sif.we
        |=> hist_update_q && hist_index_q == $past(sif.waddr))
        else $error("history not updated by move-to");
    stale_mark_a: assert property (addr_space_valid |=> &tainted_q)
        else $error("space-valid did not taint entries");
    unwritten_undef_a: assert property (accept && is_read && !sw_owned_q[sel_idx]
        |=> result_undef_q)
        else $error("unwritten entry not flagged");

    write_then_read_c: cover property (sif.we ##1 accept && is_read);
    user_trap_c: cover property (priv_trap_q);
    stale_read_c: cover property (result_valid_q && result_undef_q && $past(tainted_q != '0));
    wide_write_c: cover property (accept && is_wide);
endmodule

// file: dv/slba_pipe_model.sv
// pipeline side model: issues segment move operations and side events
// assumes callers sit just after a falling edge of clk, so every change lands off the sampling edge
module slba_pipe_model (
    input wire logic clk,
    output logic op_valid,
    output slba_pkg::slba_op_t op_code,
    output logic [3:0] segment_index_field,
    output logic [63:0] index_gpr,
    output logic [63:0] source_gpr,
    output logic supervisor,
    output logic addr_space_valid,
    output logic reload_valid,
    output logic [3:0] reload_index
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle values from time zero; space-valid starts clear as boot software leaves it
    initial begin
        op_valid = 1'b0;
        op_code = slba_pkg::SLBA_NOP;
        segment_index_field = 4'h0;
        index_gpr = 64'h0;
        source_gpr = 64'h0;
        supervisor = 1'b1;
        addr_space_valid = 1'b0;
        reload_valid = 1'b0;
        reload_index = 4'h0;
    end
    // one operation per cycle; op_valid stays up so calls run back to back
    task automatic issue(input slba_pkg::slba_op_t op, input logic [3:0] fld,
                         input logic [63:0] ig, input logic [63:0] src, input logic sup);
        op_valid = 1'b1;
        op_code = op;
        segment_index_field = fld;
        index_gpr = ig;
        source_gpr = src;
        supervisor = sup;
        addr_space_valid = 1'b0;
        reload_valid = 1'b0;
        @(negedge clk);
    endtask
    // one idle cycle carrying space-valid and reload events
    task automatic side(input logic asv, input logic rl, input logic [3:0] ri);
        op_valid = 1'b0;
        addr_space_valid = asv;
        reload_valid = rl;
        reload_index = ri;
        @(negedge clk);
    endtask
endmodule

// file: dv/tb.sv
// self-checking bench: three bridges (full, group absent, space-valid and wide absent)
// assumes the hand-over timing: answers and traps half a cycle after the taking edge
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic op_valid;
    slba_pkg::slba_op_t op_code;
    logic [3:0] fld;
    logic [63:0] ig;
    logic [63:0] src;
    logic sup;
    logic asv;
    logic rl;
    logic [3:0] ri;
    logic rv [3];
    logic ud [3];
    logic il [3];
    logic pv [3];
    logic hu [3];
    logic [63:0] res [3];
    logic [3:0] hi [3];
    int error_cnt = 0;
    int n_checks = 0;
    logic [63:0] s;
    // 100 ns period
    always #50 clk = ~clk;
    slba_pipe_model pm_inst (.clk(clk), .op_valid(op_valid), .op_code(op_code),
        .segment_index_field(fld), .index_gpr(ig), .source_gpr(src), .supervisor(sup),
        .addr_space_valid(asv), .reload_valid(rl), .reload_index(ri));
    // build 0 is complete, build 1 lacks the group, build 2 lacks space-valid and wide moves
    for (genvar g = 0; g < 3; g++) begin : gen_br
        slba_bridge #(.GROUP_EN(g != 1), .ASV_IMPL(g != 2), .WIDE_EN(g != 2))
            slba_bridge_inst (.clk(clk),
            .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
            .segment_index_field(fld), .index_gpr(ig), .source_gpr(src), .supervisor(sup),
            .addr_space_valid(asv), .reload_valid(rl), .reload_index(ri),
            .result_valid_q(rv[g]), .result_q(res[g]), .result_undef_q(ud[g]),
            .illegal_trap_q(il[g]), .priv_trap_q(pv[g]), .hist_update_q(hu[g]),
            .hist_index_q(hi[g]));
    end
    // compare and count; x never matches
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // read answer image and event image of one build
    function automatic logic [71:0] rd(input int g);
        return {6'h00, rv[g], ud[g], res[g]};
    endfunction
    function automatic logic [71:0] ev(input int g);
        return {65'h0, il[g], pv[g], hu[g], hi[g]};
    endfunction
    // source pattern per entry; upper half set so a narrow write must drop it
    function automatic logic [63:0] sv(input int k);
        return {32'hFFFF_FFFF, 4'(k), 28'h5A3C69F};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // bound is far beyond the fewer than seventy cycles the sequence needs
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (2) @(negedge clk);
        chk(rd(0) | ev(0), 72'h0);
        @(negedge clk);
        arst_n = 1'b1;
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h5, 64'h0, 64'h0, 1'b1);
        chk({70'h0, rv[0], ud[0]}, {70'h0, 2'b11});
        // write then read every entry back to back
        for (int k = 0; k < 16; k++) begin
            s = sv(k);
            pm_inst.issue(slba_pkg::SLBA_MOVE_TO, 4'(k), 64'h0, s, 1'b1);
            chk(ev(0), {65'h0, 3'b001, 4'(k)});
            pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'(k), 64'h0, 64'h0, 1'b1);
            chk(rd(0), {6'h00, 2'b10, 32'h0, s[31:0]});
        end
        // indexed forms at both ends of the range; the immediate field points elsewhere
        for (int k = 0; k < 16; k += 15) begin
            s = {32'h0, 4'(k), 28'h1234567};
            pm_inst.issue(slba_pkg::SLBA_MOVE_TO_IND, ~4'(k), s | 64'h0FFF_FFFF, s, 1'b1);
            chk(ev(0), {65'h0, 3'b001, 4'(k)});
            pm_inst.issue(slba_pkg::SLBA_MOVE_FROM_IND, ~4'(k), s, 64'h0, 1'b1);
            chk(rd(0), {6'h00, 2'b10, s});
        end
        // wide writes read back in full, top seven bits cleared
        pm_inst.issue(slba_pkg::SLBA_MOVE_TO_WIDE, 4'h7, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h7, 64'h0, 64'h0, 1'b1);
        chk(rd(0), {6'h00, 2'b10, 64'h01FF_FFFF_FFFF_FFFF});
        s = 64'hFE00_0001_8000_0001;
        pm_inst.issue(slba_pkg::SLBA_MOVE_TO_WIDE_IND, 4'h0, 64'h9000_0000, s, 1'b1);
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h9, 64'h0, 64'h0, 1'b1);
        chk(rd(0), {6'h00, 2'b10, 64'h0000_0001_8000_0001});
        // user mode is refused and leaves the entry alone
        pm_inst.issue(slba_pkg::SLBA_MOVE_TO, 4'h2, 64'h0, 64'h0, 1'b0);
        chk({69'h0, il[0], pv[0], hu[0]}, {69'h0, 3'b010});
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h2, 64'h0, 64'h0, 1'b0);
        chk({70'h0, rv[0], pv[0]}, {70'h0, 2'b01});
        s = sv(2);
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h2, 64'h0, 64'h0, 1'b1);
        chk(rd(0), {6'h00, 2'b10, 32'h0, s[31:0]});
        pm_inst.issue(slba_pkg::SLBA_NOP, 4'h2, 64'h0, 64'h0, 1'b1);
        chk({68'h0, rv[0], il[0], pv[0], hu[0]}, 72'h0);
        // space-valid seen after a write makes the read undefined; a fresh write clears it
        pm_inst.side(1'b1, 1'b0, 4'h0);
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h4, 64'h0, 64'h0, 1'b1);
        chk({70'h0, rv[0], ud[0]}, {70'h0, 2'b11});
        s = sv(4);
        pm_inst.issue(slba_pkg::SLBA_MOVE_TO, 4'h4, 64'h0, s, 1'b1);
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h4, 64'h0, 64'h0, 1'b1);
        chk(rd(0), {6'h00, 2'b10, 32'h0, s[31:0]});
        // a reload touches the history at once and takes the entry from software
        pm_inst.side(1'b0, 1'b1, 4'h6);
        chk(ev(0), {65'h0, 3'b001, 4'h6});
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h6, 64'h0, 64'h0, 1'b1);
        chk({70'h0, rv[0], ud[0]}, {70'h0, 2'b11});
        // absent builds trap every narrow move, illegal ahead of privileged
        for (int j = 0; j < 8; j++) begin
            pm_inst.issue(slba_pkg::slba_op_t'(j % 4), 4'h1, 64'h0, 64'h0, j < 4);
            for (int g = 1; g < 3; g++) begin
                chk({68'h0, rv[g], il[g], pv[g], hu[g]}, {68'h0, 4'b0100});
            end
        end
        // a wide move on the build without it traps as illegal
        pm_inst.issue(slba_pkg::SLBA_MOVE_TO_WIDE, 4'h1, 64'h0, 64'h0, 1'b1);
        chk({68'h0, rv[2], il[2], pv[2], hu[2]}, {68'h0, 4'b0100});
        // a reset in mid-run clears every record and all ownership
        pm_inst.side(1'b0, 1'b0, 4'h0);
        arst_n = 1'b0;
        @(negedge clk);
        chk(rd(0) | ev(0), 72'h0);
        arst_n = 1'b1;
        pm_inst.issue(slba_pkg::SLBA_MOVE_FROM, 4'h2, 64'h0, 64'h0, 1'b1);
        chk(rd(0), {6'h00, 2'b11, 64'h0});
        pm_inst.side(1'b0, 1'b0, 4'h0);
        print_verdict();
    end
endmodule
